/* dv/ssc_serial_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ssc_serial_host (
    output logic sck,
    output logic selN,
    output logic sdat
);
    // link idles with the clock parked low and the frame deselected
    initial begin
        sck = 1'b0;
        selN = 1'b1;
        sdat = 1'b0;
    end
    // one frame, msb first; bits beyond the last 22 are leading padding
    task automatic send(input logic [31:0] bits, input int n);
        selN = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdat = bits[i];
            #200 sck = 1'b1;
            #200 sck = 1'b0;
        end
        #200 selN = 1'b1;
        // hold is over: invert so a late sample cannot pass by luck
        sdat = ~sdat;
        #400;
    endtask : send
    // wiggle clock and data while deselected; none of it may be shifted
    task automatic noise;
        for (int i = 0; i < 6; i++) begin
            sdat = i[0];
            #200 sck = 1'b1;
            #200 sck = 1'b0;
        end
    endtask : noise
endmodule : ssc_serial_host
`default_nettype wire

/* dv/ssc_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ssc_top_asserts (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic powerdown_pin_n,
    input wire logic [2:0] loopNearLimit,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic if_section_power_on,
    input wire logic rf_section_power_on,
    input wire logic [2:0] loopTuning,
    input wire logic [2:0] pdRefTick,
    input wire logic lock_margin_warn_n,
    input wire logic aux_output_pin
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // two cycles allowed; the warning is registered from the next tuning state, so it rises with loopTuning
    a_warn_tuning: assert property ((|loopTuning) [*2] |-> lock_margin_warn_n)
        else $error("warning low while a loop tunes");
    a_warn_near: assert property (
        (loopNearLimit[0] && if_section_power_on && !loopTuning[0]) [*6] |-> lock_margin_warn_n)
        else $error("warning low while running loop is near its limit");
    a_aux_warn: assert property (aux_output_pin |-> lock_margin_warn_n)
        else $error("aux pin high without warning");
    a_pin_off: assert property (
        (!powerdown_pin_n) [*6] |-> !if_section_power_on && !rf_section_power_on)
        else $error("section powered while pin holds it off");
    a_pwrup_tune: assert property ($rose(if_section_power_on) |-> ##[0:3] loopTuning[0])
        else $error("IF loop powered up without tuning");
    a_tick_single: assert property (pdRefTick[0] |=> !pdRefTick[0])
        else $error("reference tick longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held two cycles");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
endmodule : ssc_top_asserts
bind ssc_top ssc_top_asserts chk (.clk, .reset_n, .powerdown_pin_n, .loopNearLimit, .psel,
    .penable, .pready, .pslverr, .if_section_power_on, .rf_section_power_on, .loopTuning,
    .pdRefTick, .lock_margin_warn_n, .aux_output_pin);
`default_nettype wire

/* dv/ssc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssc_regs.svh"
module ssc_top_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    wire serialShiftClock, serial_frame_select_n, serial_data_in;
    logic powerdown_pin_n = 1'b0, reference_input = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [2:0] vcoFeedbackIn = 3'h0, loopNearLimit = 3'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic pready, pslverr, if_section_power_on, rf_section_power_on, refAmpOn;
    logic upperRfLoopActive, lock_margin_warn_n, aux_output_pin;
    logic [2:0] loopTuning, pdRefTick, pdFbTick;
    logic [1:0] ifOutDivide;
    int mismatches = 0, checks = 0, cyc = 0, refCnt = 0, ifCnt = 0, rfCnt = 0;
    int sr = 0; // model of the device shift register
    int regs[9]; // model of the stored words
    logic expUp = 1'b0; // expected active RF loop
    ssc_top DUT (.clk, .reset_n, .serialShiftClock, .serial_frame_select_n,
        .serial_data_in, .powerdown_pin_n, .reference_input, .vcoFeedbackIn, .loopNearLimit,
        .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .if_section_power_on, .rf_section_power_on, .refAmpOn, .upperRfLoopActive,
        .loopTuning, .ifOutDivide, .pdRefTick, .pdFbTick, .lock_margin_warn_n,
        .aux_output_pin);
    ssc_serial_host host (.sck(serialShiftClock), .selN(serial_frame_select_n),
        .sdat(serial_data_in));
    initial forever #25 clk = ~clk;
    // reference edge every 6 cycles, vco edge every 8; tick counters beside
    always @(posedge clk) begin
        cyc <= cyc + 1;
        reference_input <= (cyc % 6) < 3;
        vcoFeedbackIn <= {3{(cyc % 8) < 4}};
        refCnt <= refCnt + pdRefTick[0];
        ifCnt <= ifCnt + pdFbTick[0];
        rfCnt <= rfCnt + (pdFbTick[1] | pdFbTick[2]);
    end
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task wrap_up;
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up
    // one apb transfer; waits for pready under a bound
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // look at pready once it has settled after the edge, so the answer
        // and the completing edge are never confused with each other
        #1;
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 50) begin
            chk("pready", 1, 0);
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        // the edge that samples psel, penable and pready high completes the access
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // send a frame and mirror it into the model
    task frame(input logic [31:0] bits, input int n);
        host.send(bits, n);
        for (int i = n - 1; i >= 0; i--) sr = ((sr << 1) | bits[i]) & 32'h3FFFFF;
        if ((sr & 15) <= 8) regs[sr & 15] = sr >> 4;
        repeat (10) @(posedge clk);
    endtask : frame
    // wait for all loops to finish tuning, bounded
    task settle;
        int n;
        n = 0;
        while (loopTuning !== 3'b000 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) begin
            chk("tuning end", 0, loopTuning);
            wrap_up();
        end
    endtask : settle
    initial begin
        logic [31:0] rd;
        logic e;
        int d, r0, i0, f0;
        void'($urandom(54665));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk("warn reset", 1, lock_margin_warn_n);
        // word0: aux select 011, halving on, every IF divide code, padded frames
        for (int k = 0; k < 4; k++) begin
            d = ($urandom & 32'h3FE07) | (k << 7) | 32'h58;
            frame(($urandom & 32'hFFC00000) | (d << 4) | `SSC_A_MAIN, 22 + k);
            chk("ifdiv", k, ifOutDivide);
        end
        // N = 3 and R = 2 everywhere; watch which RF loop is active
        for (int a = 3; a <= 8; a++) begin
            frame(((a < 6 ? 3 : 2) << 4) | a, 22);
            if (a % 3 != 2) expUp = (a % 3 == 0);
            chk("upper active", expUp, upperRfLoopActive);
        end
        frame(($urandom << 4) | 9, 22);
        frame(($urandom << 4) | 15, 22);
        host.noise();
        frame(32'h1, 4);
        // power bits while the pin holds the device off
        frame(32'h32, 22);
        chk("pwr pin low", 0, {if_section_power_on, rf_section_power_on});
        powerdown_pin_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk("pwr up", 3, {if_section_power_on, rf_section_power_on});
        chk("amp", 1, refAmpOn);
        chk("tune up", 5, loopTuning);
        chk("warn tune", 1, lock_margin_warn_n);
        settle();
        chk("warn done", 0, lock_margin_warn_n);
        chk("aux done", 0, aux_output_pin);
        // 80 reference edges halved then /2, 60 vco edges /3 and /6
        r0 = refCnt;
        i0 = ifCnt;
        f0 = rfCnt;
        repeat (480) @(posedge clk);
        chk("ref ticks", 1, (refCnt - r0) inside {[19:21]});
        chk("if ticks", 1, (ifCnt - i0) inside {[19:21]});
        chk("rf ticks", 1, (rfCnt - f0) inside {[9:11]});
        loopNearLimit <= 3'b001;
        repeat (8) @(posedge clk);
        chk("warn near", 1, lock_margin_warn_n);
        chk("aux near", 1, aux_output_pin);
        apb(`SSC_APB_CTRL, 1'b1, 32'h3, rd, e);
        loopNearLimit <= 3'b000;
        repeat (3) @(posedge clk);
        chk("retune", 5, loopTuning);
        settle();
        frame(32'h50 | `SSC_A_N_IF, 22);
        chk("freq tune", 1, loopTuning[0]);
        settle();
        apb(`SSC_APB_STATUS, 1'b0, 32'h0, rd, e);
        chk("status", 32'h30 | (expUp << 3), rd & 32'h38);
        apb(12'h100, 1'b0, 32'h0, rd, e);
        chk("unmapped", 1, e);
        frame(32'h2, 22);
        chk("pwr zeros", 0, {if_section_power_on, rf_section_power_on});
        frame(32'h32, 22);
        chk("pwr ones", 3, {if_section_power_on, rf_section_power_on});
        powerdown_pin_n <= 1'b0;
        repeat (8) @(posedge clk);
        chk("pwr pin fall", 0, {if_section_power_on, rf_section_power_on});
        for (int a = 0; a < 9; a++) begin
            apb(`SSC_APB_SHADOW + 12'(4 * a), 1'b0, 32'h0, rd, e);
            chk("stored word", regs[a], rd);
        end
        wrap_up();
    end
endmodule : ssc_top_tb
`default_nettype wire

/* hw/ssc_phase_div.sv */
`timescale 1ns/1ps
`default_nettype none
module ssc_phase_div #(
    parameter int W = 19
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic restart,
    input wire logic tickIn,
    input wire logic [W-1:0] divisor,
    output logic tickOut
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } ssc_div_s;

    ssc_div_s st;
    ssc_div_s next_st;

    // one output tick per divisor input ticks; zero acts as one
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (restart) begin
            next_st.cnt = '0;
        end else if (tickIn) begin
            if (divisor == '0 || st.cnt >= divisor - W'(1)) begin
                next_st.cnt = '0;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tickOut = st.tick;
endmodule : ssc_phase_div
`default_nettype wire

/* hw/ssc_pkg.sv */
`include "ssc_regs.svh"
package ssc_pkg;
    // per-loop tuning state, one-hot
    typedef enum logic [2:0] {
        SSC_OFF = 3'b001,
        SSC_TUNE = 3'b010,
        SSC_RUN = 3'b100
    } ssc_tune_e;

    // serial receiver state
    typedef struct packed {
        logic clkMeta;
        logic clkSync;
        logic clkLast;
        logic senMeta;
        logic senSync;
        logic senLast;
        logic datMeta;
        logic datSync;
        logic [`SSC_WORD_BITS-1:0] shift;
        logic wordValid;
        logic [`SSC_ADDR_BITS-1:0] wordAddr;
        logic [`SSC_DATA_BITS-1:0] wordData;
    } ssc_rx_s;

    // top-level state
    typedef struct packed {
        logic pinMeta;
        logic pinSync;
        logic refMeta;
        logic refSync;
        logic refLast;
        logic refPhase;
        logic refPulse;
        logic [2:0] vcoMeta;
        logic [2:0] vcoSync;
        logic [2:0] vcoLast;
        logic [2:0] vcoPulse;
        logic [2:0] nearMeta;
        logic [2:0] nearSync;
        logic [8:0][`SSC_DATA_BITS-1:0] word;
        logic ifPwr;
        logic rfPwr;
        logic refAmp;
        logic upperActive;
        ssc_tune_e [2:0] tune;
        logic [2:0][3:0] tuneCnt;
        logic [2:0] restart;
        logic warnN;
        logic aux;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ssc_top_s;
endpackage : ssc_pkg

/* hw/ssc_regs.svh */
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH
// serial word layout
`define SSC_WORD_BITS 22
`define SSC_DATA_BITS 18
`define SSC_ADDR_BITS 4
// serial register addresses
`define SSC_A_MAIN 4'h0
`define SSC_A_GAIN 4'h1
`define SSC_A_PWR 4'h2
`define SSC_A_N_UP 4'h3
`define SSC_A_N_LO 4'h4
`define SSC_A_N_IF 4'h5
`define SSC_A_R_UP 4'h6
`define SSC_A_R_LO 4'h7
`define SSC_A_R_IF 4'h8
`define SSC_A_LAST 4'h8
// field positions
`define SSC_HALVE_BIT 6
`define SSC_AUX_LSB 3
`define SSC_IFDIV_LSB 7
`define SSC_PWR_RF_BIT 0
`define SSC_PWR_IF_BIT 1
`define SSC_AUX_WARN 3'h3
// reset values
`define SSC_WORD_RST 18'h00000
// self-tuning length in phase detector update periods
`define SSC_TUNE_PERIODS 4'hD
// apb byte offsets
`define SSC_APB_STATUS 12'h000
`define SSC_APB_CTRL 12'h004
`define SSC_APB_SHADOW 12'h040
`endif

/* hw/ssc_serial_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module ssc_serial_rx
    import ssc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic serialShiftClock,
    input wire logic serial_frame_select_n,
    input wire logic serial_data_in,
    output logic wordValid,
    output logic [`SSC_ADDR_BITS-1:0] wordAddr,
    output logic [`SSC_DATA_BITS-1:0] wordData
);
    ssc_rx_s st;
    ssc_rx_s next_st;

    // pins pass two flops; edges are found on the second stage only
    always_comb begin
        next_st = st;
        next_st.clkMeta = serialShiftClock;
        next_st.clkSync = st.clkMeta;
        next_st.clkLast = st.clkSync;
        next_st.senMeta = serial_frame_select_n;
        next_st.senSync = st.senMeta;
        next_st.senLast = st.senSync;
        next_st.datMeta = serial_data_in;
        next_st.datSync = st.datMeta;
        next_st.wordValid = 1'b0;
        // shift only inside a frame; older leading bits fall off the top
        if (!st.senSync && st.clkSync && !st.clkLast) begin
            next_st.shift = {st.shift[`SSC_WORD_BITS-2:0], st.datSync};
        end
        // frame end: last four bits are the address, the 18 before are data
        if (st.senSync && !st.senLast) begin
            next_st.wordValid = 1'b1;
            next_st.wordAddr = st.shift[`SSC_ADDR_BITS-1:0];
            next_st.wordData = st.shift[`SSC_WORD_BITS-1:`SSC_ADDR_BITS];
        end
    end

    // select idles high, so its stages reset high to avoid a false frame end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.senMeta <= 1'b1;
            st.senSync <= 1'b1;
            st.senLast <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign wordValid = st.wordValid;
    assign wordAddr = st.wordAddr;
    assign wordData = st.wordData;
endmodule : ssc_serial_rx
`default_nettype wire

/* hw/ssc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ssc_top
    import ssc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    // three-wire serial link
    input wire logic serialShiftClock,
    input wire logic serial_frame_select_n,
    input wire logic serial_data_in,
    // device pins
    input wire logic powerdown_pin_n,
    input wire logic reference_input,
    input wire logic [2:0] vcoFeedbackIn,
    input wire logic [2:0] loopNearLimit,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // synthesizer controls
    output logic if_section_power_on,
    output logic rf_section_power_on,
    output logic refAmpOn,
    output logic upperRfLoopActive,
    output logic [2:0] loopTuning,
    output logic [1:0] ifOutDivide,
    output logic [2:0] pdRefTick,
    output logic [2:0] pdFbTick,
    output logic lock_margin_warn_n,
    output logic aux_output_pin
);
    // loop index 0 is IF, 1 the upper RF loop, 2 the lower RF loop
    ssc_top_s st;
    ssc_top_s next_st;

    logic wordValid; // one-cycle pulse at frame end
    logic [`SSC_ADDR_BITS-1:0] wordAddr; // destination of the word
    logic [`SSC_DATA_BITS-1:0] wordData; // data field of the word
    logic [2:0] refTick; // divided reference per loop
    logic [2:0] fbTick; // divided feedback per loop
    logic [2:0][18:0] refDivisor; // R per loop
    logic [2:0][18:0] fbDivisor; // N or 2N per loop

    // serial receiver; runs whatever the power state
    ssc_serial_rx u_rx (
        .clk(clk),
        .reset_n(reset_n),
        .serialShiftClock(serialShiftClock),
        .serial_frame_select_n(serial_frame_select_n),
        .serial_data_in(serial_data_in),
        .wordValid(wordValid),
        .wordAddr(wordAddr),
        .wordData(wordData)
    );

    // divisor selection: RF feedback doubles N, IF uses N as is
    always_comb begin
        refDivisor[0] = {1'b0, st.word[`SSC_A_R_IF]};
        refDivisor[1] = {1'b0, st.word[`SSC_A_R_UP]};
        refDivisor[2] = {1'b0, st.word[`SSC_A_R_LO]};
        fbDivisor[0] = {1'b0, st.word[`SSC_A_N_IF]};
        fbDivisor[1] = {st.word[`SSC_A_N_UP], 1'b0};
        fbDivisor[2] = {st.word[`SSC_A_N_LO], 1'b0};
    end

    // two dividers per loop feed the phase detector
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_loop
            // reference side, fed by the optionally halved reference
            ssc_phase_div #(.W(19)) u_ref (
                .clk(clk),
                .reset_n(reset_n),
                .restart(st.restart[gi]),
                .tickIn(st.refPulse),
                .divisor(refDivisor[gi]),
                .tickOut(refTick[gi])
            );
            // feedback side, fed by synchronised vco rising-edge pulses
            ssc_phase_div #(.W(19)) u_fb (
                .clk(clk),
                .reset_n(reset_n),
                .restart(st.restart[gi]),
                .tickIn(st.vcoPulse[gi]),
                .divisor(fbDivisor[gi]),
                .tickOut(fbTick[gi])
            );
        end
    endgenerate

    logic apbSetup; // setup phase of an apb transfer
    logic apbWrite; // completing apb write
    logic [3:0] shadowIdx; // serial register index under apb
    logic shadowHit; // apb address falls in the read-back window
    logic [1:0] retune; // software retune strobes: IF, active RF
    logic [8:0] wrote; // serial register written this cycle
    logic [2:0] loopOn; // loop powered, new value
    logic [2:0] wasOn; // loop powered, old value
    logic [2:0] freqWr; // loop frequency reprogrammed
    logic [2:0] start; // begin self-tuning
    logic [2:0] loopRun; // loop past tuning
    logic anyTune; // some loop tuning
    logic refEdge; // rising edge of the reference

    // all next-state logic of the block
    always_comb begin
        next_st = st;
        // pin synchronisers; the first stage is never read below
        next_st.pinMeta = powerdown_pin_n;
        next_st.pinSync = st.pinMeta;
        next_st.refMeta = reference_input;
        next_st.refSync = st.refMeta;
        next_st.refLast = st.refSync;
        next_st.vcoMeta = vcoFeedbackIn;
        next_st.vcoSync = st.vcoMeta;
        next_st.vcoLast = st.vcoSync;
        next_st.vcoPulse = st.vcoSync & ~st.vcoLast;
        next_st.nearMeta = loopNearLimit;
        next_st.nearSync = st.nearMeta;

        // reference halving drops every other edge
        refEdge = st.refSync && !st.refLast;
        next_st.refPulse = 1'b0;
        if (refEdge) begin
            next_st.refPhase = !st.refPhase;
            if (st.word[`SSC_A_MAIN][`SSC_HALVE_BIT]) begin
                next_st.refPulse = st.refPhase;
            end else begin
                next_st.refPulse = 1'b1;
            end
        end

        // apb decode; writes land at the edge that completes the access
        apbSetup = psel && !penable;
        apbWrite = psel && penable && st.pready && pwrite;
        shadowIdx = paddr[5:2];
        shadowHit = paddr[11:6] == `SSC_APB_SHADOW >> 6 && shadowIdx <= `SSC_A_LAST;
        retune = 2'h0;
        if (apbWrite && paddr == `SSC_APB_CTRL) begin
            retune = pwdata[1:0];
        end

        // serial writes; out-of-range addresses are dropped
        wrote = 9'h000;
        if (wordValid && wordAddr <= `SSC_A_LAST) begin
            next_st.word[wordAddr] = wordData;
            wrote[wordAddr] = 1'b1;
        end

        // the last RF divider written picks the active RF loop
        if (wrote[`SSC_A_N_UP] || wrote[`SSC_A_R_UP]) begin
            next_st.upperActive = 1'b1;
        end else if (wrote[`SSC_A_N_LO] || wrote[`SSC_A_R_LO]) begin
            next_st.upperActive = 1'b0;
        end

        // a low pin overrides the power bits; both edges act at once
        next_st.ifPwr = st.pinSync && next_st.word[`SSC_A_PWR][`SSC_PWR_IF_BIT];
        next_st.rfPwr = st.pinSync && next_st.word[`SSC_A_PWR][`SSC_PWR_RF_BIT];
        next_st.refAmp = next_st.ifPwr || next_st.rfPwr;

        // which loops run now and ran before
        loopOn[0] = next_st.ifPwr;
        loopOn[1] = next_st.rfPwr && next_st.upperActive;
        loopOn[2] = next_st.rfPwr && !next_st.upperActive;
        wasOn[0] = st.ifPwr;
        wasOn[1] = st.rfPwr && st.upperActive;
        wasOn[2] = st.rfPwr && !st.upperActive;
        freqWr[0] = wrote[`SSC_A_N_IF] || wrote[`SSC_A_R_IF];
        freqWr[1] = wrote[`SSC_A_N_UP] || wrote[`SSC_A_R_UP];
        freqWr[2] = wrote[`SSC_A_N_LO] || wrote[`SSC_A_R_LO];
        start[0] = loopOn[0] && (!wasOn[0] || freqWr[0] || retune[0]);
        start[1] = loopOn[1] && (!wasOn[1] || freqWr[1] || retune[1]);
        start[2] = loopOn[2] && (!wasOn[2] || freqWr[2] || retune[1]);

        // per-loop tuning sequencer, counted in reference update periods
        for (int i = 0; i < 3; i++) begin
            next_st.restart[i] = start[i] || !loopOn[i];
            if (!loopOn[i]) begin
                // unpowered or unselected loop holds still
                next_st.tune[i] = SSC_OFF;
                next_st.tuneCnt[i] = 4'h0;
            end else if (start[i]) begin
                next_st.tune[i] = SSC_TUNE;
                next_st.tuneCnt[i] = 4'h0;
            end else begin
                unique case (st.tune[i])
                    SSC_OFF: begin
                        next_st.tune[i] = SSC_TUNE;
                    end
                    SSC_TUNE: begin
                        // tuning ends after the set number of updates
                        if (refTick[i]) begin
                            if (st.tuneCnt[i] == `SSC_TUNE_PERIODS - 4'h1) begin
                                next_st.tune[i] = SSC_RUN;
                            end else begin
                                next_st.tuneCnt[i] = st.tuneCnt[i] + 4'h1;
                            end
                        end
                    end
                    SSC_RUN: begin
                        next_st.tune[i] = SSC_RUN;
                    end
                    default: begin
                        // illegal code recovers by retuning
                        next_st.tune[i] = SSC_TUNE;
                        next_st.tuneCnt[i] = 4'h0;
                    end
                endcase
            end
        end

        // warning: high while tuning, or when a running loop nears its limit
        anyTune = 1'b0;
        loopRun = 3'h0;
        for (int i = 0; i < 3; i++) begin
            anyTune = anyTune || next_st.tune[i] == SSC_TUNE;
            loopRun[i] = next_st.tune[i] == SSC_RUN;
        end
        next_st.warnN = anyTune || |(st.nearSync & loopRun);
        if (st.word[`SSC_A_MAIN][`SSC_AUX_LSB +: 3] == `SSC_AUX_WARN) begin
            next_st.aux = next_st.warnN;
        end else begin
            // other selections are not built here and read low
            next_st.aux = 1'b0;
        end

        // apb answer: data and ready are prepared in the setup cycle
        next_st.pready = apbSetup;
        next_st.pslverr = 1'b0;
        next_st.prdata = 32'h0000_0000;
        if (apbSetup) begin
            if (paddr == `SSC_APB_STATUS) begin
                next_st.prdata = {24'h00_0000, st.pinSync, st.warnN, st.rfPwr,
                                  st.ifPwr, st.upperActive, loopTuning};
            end else if (paddr == `SSC_APB_CTRL) begin
                // retune strobes read back as zero
                next_st.prdata = 32'h0000_0000;
            end else if (shadowHit) begin
                next_st.prdata = {14'h0000, st.word[shadowIdx]};
            end else begin
                // unmapped address answers with an error
                next_st.pslverr = 1'b1;
            end
        end
    end

    // single state register; reset leaves everything off and quiet except the warning, which starts high
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.tune <= {SSC_OFF, SSC_OFF, SSC_OFF};
            st.warnN <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state flops
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign if_section_power_on = st.ifPwr;
    assign rf_section_power_on = st.rfPwr;
    assign refAmpOn = st.refAmp;
    assign upperRfLoopActive = st.upperActive;
    assign ifOutDivide = st.word[`SSC_A_MAIN][`SSC_IFDIV_LSB +: 2];
    assign lock_margin_warn_n = st.warnN;
    assign aux_output_pin = st.aux;
    assign pdRefTick = refTick;
    assign pdFbTick = fbTick;

    // tuning flags per loop
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            loopTuning[i] = st.tune[i] == SSC_TUNE;
        end
    end
endmodule : ssc_top
`default_nettype wire
